// file: core/imscd_brg.sv
// reload-based baud rate counter that times the SCL high, SDA release and tail phases of the stop
`timescale 1ns/1ns
`default_nettype none

module imscd_brg #(
	parameter int RELOAD_W = 7
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// control
	input  wire logic                load,
	input  wire logic [RELOAD_W-1:0] reload,
	// status
	output logic                     expired
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (RELOAD_W < 1 || RELOAD_W > 16)
	begin : g_bad_width
		$error("reload width out of range");
	end

	logic [RELOAD_W-1:0] count_reg;
	logic                run_reg;

	// count down from the reload value, pulse once on reaching zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= '0;
			run_reg   <= 1'b0;
			expired   <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (load)
			begin
				count_reg <= reload;
				run_reg   <= 1'b1;
			end
			else if (run_reg)
			begin
				if (count_reg == '0)
				begin
					run_reg <= 1'b0;
					expired <= 1'b1;
				end
				else
					count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule // imscd_brg

`default_nettype wire

// file: core/imscd_pkg.sv
// shared constants and types of the stop and collision logic
package imscd_pkg;

	// ----------------------------------------------------------------
	// register map (word index on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_TRANSFER_BUFFER = 3'h0;
	localparam logic [2:0] ADDR_RELOAD_OR_MASK  = 3'h1; // reload and mask share it
	localparam logic [2:0] ADDR_CONTROL_ONE     = 3'h2;
	localparam logic [2:0] ADDR_CONTROL_TWO     = 3'h3;
	localparam logic [2:0] ADDR_PORT_STATUS     = 3'h4;
	localparam logic [2:0] ADDR_EVENT_STATUS    = 3'h5;
	localparam logic [2:0] ADDR_EVENT_MASK      = 3'h6;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL1_WRITE_COLLISION = 7;
	localparam int CTL1_PORT_ENABLE     = 5;
	localparam int CTL1_MODE_LSB        = 0;
	localparam int CTL2_STOP_REQUEST    = 2;
	localparam int CTL2_MASK_LSB        = 1;
	localparam int CTL2_ACK_STATUS      = 6;
	localparam int STAT_STOP_SEEN       = 4;
	localparam int EVT_PORT_EVENT       = 0;
	localparam int EVT_COLLISION        = 1;

	// ----------------------------------------------------------------
	// port modes in the low nibble of the first control register
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_MASTER      = 4'h8;
	localparam logic [3:0] MODE_SLAVE_MASK7 = 4'h9;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [7:0] RST_MASK      = 8'hff;
	localparam logic [4:0] RST_CTL2_MASK = 5'h1f;
	localparam logic [6:0] RST_RELOAD    = 7'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// one sample of both bus lines
	typedef struct packed {
		logic sda;
		logic scl;
	} imscd_line_t;

	// phases of the stop sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SDA_LOW,
		ST_SCL_REL,
		ST_SCL_HIGH,
		ST_SDA_REL,
		ST_TAIL
	} imscd_state_t;

endpackage

// file: core/imscd_stop.sv
// stop condition generator with bus collision detection and port registers
`timescale 1ns/1ns
`default_nettype none

// Contract
// - stop request bit starts stop, SDA low
// - release SCL only after SDA sampled low
// - SCL high loads counter from reload field
// - SDA low after counter expiry is collision
// - SCL low before SDA release is collision
// - collision aborts, releases, clears request, flags
// - stop seen, one period later event flag
// - mask shares reload address in mask mode
// - slave mode remaps second control bits five-one
module imscd_stop #(
	parameter int RELOAD_W = 7
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// serial data line, open drain
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// serial clock line, open drain
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	// flags to the rest of the port
	output logic            stop_request_bit,
	output logic            collision_flag,
	output logic            port_event_flag,
	output logic            irq
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (RELOAD_W != 7)
	begin : g_bad_reload
		$error("reload field must be seven bits wide");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	imscd_pkg::imscd_line_t  pin_s1_reg;
	imscd_pkg::imscd_line_t  pin_s2_reg;
	imscd_pkg::imscd_line_t  pin_s3_reg;
	imscd_pkg::imscd_line_t  line_reg;
	imscd_pkg::imscd_state_t state_reg;

	logic [7:0] buffer_reg;
	logic [7:0] reload_reg;
	logic [7:0] mask_reg;
	logic [7:0] ctl1_reg;
	logic [7:0] ctl2_reg;
	logic [4:0] ctl2_mask_reg;
	logic       stop_seen_reg;
	logic [1:0] evt_stat_reg;
	logic [1:0] evt_mask_reg;
	logic       brg_load_reg;
	logic       brg_expired;
	logic       collide;
	logic       finish;
	logic       stop_start;
	logic       stop_busy;
	logic [1:0] evt_set;

	// decode of the port mode
	function automatic logic mode_is(input logic [7:0] ctl, input logic [3:0] mode);
		mode_is = ctl[imscd_pkg::CTL1_PORT_ENABLE] && (ctl[3:0] == mode);
	endfunction

	logic master_mode;
	logic mask_mode;

	assign master_mode = mode_is(ctl1_reg, imscd_pkg::MODE_MASTER);
	assign mask_mode   = mode_is(ctl1_reg, imscd_pkg::MODE_SLAVE_MASK7);
	assign stop_busy   = (state_reg != imscd_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// three stages; the level moves only when stages two and three agree,
	// so a single-sample glitch never reaches the sequencer
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg <= '1;
			pin_s2_reg <= '1;
			pin_s3_reg <= '1;
			line_reg   <= '1;
		end
		else
		begin
			pin_s1_reg <= '{sda: sda_i, scl: scl_i};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			if (pin_s2_reg.sda == pin_s3_reg.sda)
				line_reg.sda <= pin_s3_reg.sda;
			if (pin_s2_reg.scl == pin_s3_reg.scl)
				line_reg.scl <= pin_s3_reg.scl;
		end
	end

	// ----------------------------------------------------------------
	// baud rate counter
	// ----------------------------------------------------------------
	imscd_brg #(
		.RELOAD_W (RELOAD_W)
	) u_brg (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (brg_load_reg),
		.reload   (reload_reg[RELOAD_W-1:0]),
		.expired  (brg_expired)
	);

	// ----------------------------------------------------------------
	// stop sequencer
	// ----------------------------------------------------------------
	// stop request start
	assign stop_start = reg_wr && (reg_addr == imscd_pkg::ADDR_CONTROL_TWO)
		&& reg_wdata[imscd_pkg::CTL2_STOP_REQUEST] && master_mode && !stop_busy;

	// collision and completion decoded from the current phase
	always_comb
	begin
		collide = 1'b0;
		finish  = 1'b0;
		unique case (state_reg)
			imscd_pkg::ST_SCL_HIGH:
				collide = !line_reg.scl;
			imscd_pkg::ST_SDA_REL:
				collide = brg_expired && !(line_reg.sda && line_reg.scl);
			imscd_pkg::ST_TAIL:
				finish = brg_expired;
			imscd_pkg::ST_IDLE, imscd_pkg::ST_SDA_LOW, imscd_pkg::ST_SCL_REL:
				collide = 1'b0;
		endcase
	end

	// phase walk; a disabled port drops any sequence in flight
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg    <= imscd_pkg::ST_IDLE;
			brg_load_reg <= 1'b0;
			sda_oe       <= 1'b0;
			scl_oe       <= 1'b0;
		end
		else
		begin
			brg_load_reg <= 1'b0;
			if (!master_mode || collide)
			begin
				state_reg <= imscd_pkg::ST_IDLE;
				sda_oe    <= 1'b0;
				scl_oe    <= 1'b0;
			end
			else
			begin
				unique case (state_reg)
					imscd_pkg::ST_IDLE:
						if (stop_start)
						begin
							state_reg <= imscd_pkg::ST_SDA_LOW;
							sda_oe    <= 1'b1;
							scl_oe    <= 1'b1;
						end
					imscd_pkg::ST_SDA_LOW:
						if (!line_reg.sda)
						begin
							state_reg <= imscd_pkg::ST_SCL_REL;
							scl_oe    <= 1'b0;
						end
					imscd_pkg::ST_SCL_REL:
						if (line_reg.scl)
						begin
							state_reg    <= imscd_pkg::ST_SCL_HIGH;
							brg_load_reg <= 1'b1;
						end
					imscd_pkg::ST_SCL_HIGH:
						if (brg_expired)
						begin
							state_reg    <= imscd_pkg::ST_SDA_REL;
							sda_oe       <= 1'b0;
							brg_load_reg <= 1'b1;
						end
					imscd_pkg::ST_SDA_REL:
						if (brg_expired)
						begin
							state_reg    <= imscd_pkg::ST_TAIL;
							brg_load_reg <= 1'b1;
						end
					imscd_pkg::ST_TAIL:
						if (finish)
							state_reg <= imscd_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// port registers
	// ----------------------------------------------------------------
	// open drain: output data is always low, the enable does the work
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end
		else
		begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end
	end

	// buffer, reload and mask; writes to the buffer during a stop are refused
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			buffer_reg <= imscd_pkg::RST_BYTE;
			reload_reg <= {1'b0, imscd_pkg::RST_RELOAD};
			mask_reg   <= imscd_pkg::RST_MASK;
		end
		else if (reg_wr)
		begin
			if (reg_addr == imscd_pkg::ADDR_TRANSFER_BUFFER && !stop_busy)
				buffer_reg <= reg_wdata;
			if (reg_addr == imscd_pkg::ADDR_RELOAD_OR_MASK)
			begin
				if (mask_mode)
					mask_reg <= reg_wdata;
				else
					reload_reg <= reg_wdata;
			end
		end
	end

	// first control register; write collision flag is sticky until written 0
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctl1_reg <= imscd_pkg::RST_BYTE;
		else
		begin
			if (reg_wr && reg_addr == imscd_pkg::ADDR_CONTROL_ONE)
				ctl1_reg <= reg_wdata;
			// a refused buffer write wins over a same-cycle clear
			if (reg_wr && reg_addr == imscd_pkg::ADDR_TRANSFER_BUFFER && stop_busy)
				ctl1_reg[imscd_pkg::CTL1_WRITE_COLLISION] <= 1'b1;
		end
	end

	// second control register and its slave-mode mask view
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl2_reg      <= imscd_pkg::RST_BYTE;
			ctl2_mask_reg <= imscd_pkg::RST_CTL2_MASK;
		end
		else
		begin
			if (reg_wr && reg_addr == imscd_pkg::ADDR_CONTROL_TWO)
			begin
				if (!master_mode)
				begin
					// bits five to one become mask bits
					ctl2_mask_reg <= reg_wdata[imscd_pkg::CTL2_MASK_LSB +: 5];
					ctl2_reg[7]   <= reg_wdata[7];
					ctl2_reg[0]   <= reg_wdata[0];
				end
				else
				begin
					ctl2_reg <= reg_wdata;
					ctl2_reg[imscd_pkg::CTL2_ACK_STATUS] <= 1'b0;
					// request only latches when the sequencer takes it
					ctl2_reg[imscd_pkg::CTL2_STOP_REQUEST] <=
						ctl2_reg[imscd_pkg::CTL2_STOP_REQUEST] | stop_start;
				end
			end
			if (collide || finish || !master_mode)
				ctl2_reg[imscd_pkg::CTL2_STOP_REQUEST] <= 1'b0;
		end
	end

	// stop-seen status; cleared by a new request or a disabled port
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stop_seen_reg <= 1'b0;
		else if (!ctl1_reg[imscd_pkg::CTL1_PORT_ENABLE] || stop_start)
			stop_seen_reg <= 1'b0;
		else if (state_reg == imscd_pkg::ST_SDA_REL && brg_expired && !collide)
			stop_seen_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	assign evt_set = {collide, finish};

	// sticky events cleared by reading them; a new event wins over the read
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_stat_reg <= 2'h0;
			evt_mask_reg <= 2'h0;
		end
		else
		begin
			if (reg_rd && reg_addr == imscd_pkg::ADDR_EVENT_STATUS)
				evt_stat_reg <= evt_set;
			else
				evt_stat_reg <= evt_stat_reg | evt_set;
			if (reg_wr && reg_addr == imscd_pkg::ADDR_EVENT_MASK)
				evt_mask_reg <= reg_wdata[1:0];
		end
	end

	// flag outputs and interrupt level, all registered
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stop_request_bit <= 1'b0;
			collision_flag   <= 1'b0;
			port_event_flag  <= 1'b0;
			irq              <= 1'b0;
		end
		else
		begin
			stop_request_bit <= ctl2_reg[imscd_pkg::CTL2_STOP_REQUEST];
			collision_flag   <= evt_stat_reg[imscd_pkg::EVT_COLLISION];
			port_event_flag  <= evt_stat_reg[imscd_pkg::EVT_PORT_EVENT];
			irq              <= |(evt_stat_reg & evt_mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else
		begin
			unique case (reg_addr)
				imscd_pkg::ADDR_TRANSFER_BUFFER:
					reg_rdata <= buffer_reg;
				imscd_pkg::ADDR_RELOAD_OR_MASK:
					reg_rdata <= mask_mode ? mask_reg : reload_reg;
				imscd_pkg::ADDR_CONTROL_ONE:
					reg_rdata <= ctl1_reg;
				imscd_pkg::ADDR_CONTROL_TWO:
					reg_rdata <= master_mode ? ctl2_reg
						: {ctl2_reg[7], 1'b0, ctl2_mask_reg, ctl2_reg[0]};
				imscd_pkg::ADDR_PORT_STATUS:
					reg_rdata <= {3'h0, stop_seen_reg, 4'h0};
				imscd_pkg::ADDR_EVENT_STATUS:
					reg_rdata <= {6'h00, evt_stat_reg};
				imscd_pkg::ADDR_EVENT_MASK:
					reg_rdata <= {6'h00, evt_mask_reg};
				default:
					reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule // imscd_stop

`default_nettype wire

// file: verif/imscd_bus_model.sv
// far side of the bus: pull-ups, another master and a clock stretcher
`timescale 1ns/1ns
`default_nettype none
module imscd_bus_model (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// design enables and other master pulls
	input  wire logic sda_oe,
	input  wire logic scl_oe,
	input  wire logic hold_sda,
	input  wire logic hold_scl,
	// wired lines
	output logic      sda,
	output logic      scl
);
	logic [3:0] stretch_reg;
	// stretch released clock
	// a slave holds scl one 160 ns link period after each release
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stretch_reg <= 4'h0;
		else if (scl_oe)
			stretch_reg <= 4'h8;
		else if (stretch_reg != 4'h0)
			stretch_reg <= stretch_reg - 4'h1;
	end
	assign sda = !(sda_oe || hold_sda);
	assign scl = !(scl_oe || hold_scl || stretch_reg != 4'h0);
endmodule // imscd_bus_model
`default_nettype wire

// file: verif/imscd_stop_bench.sv
// self-checking bench of the stop and collision logic
`timescale 1ns/1ns
`default_nettype none
module imscd_stop_bench;
	logic       core_clk, rst_n, reg_wr, reg_rd, hold_sda, hold_scl, sda, scl;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic       sda_o, sda_oe, scl_o, scl_oe, stop_request_bit, collision_flag;
	logic       port_event_flag, irq;
	int         failures, total_checks, n, m;
	logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h3e, 8'h00, 8'h00, 8'h00, 8'h00};

	imscd_stop imscd_stop_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .sda_i(sda), .sda_o, .sda_oe, .scl_i(scl), .scl_o, .scl_oe,
		.stop_request_bit, .collision_flag, .port_event_flag, .irq);
	imscd_bus_model imscd_bus_model_i (.core_clk, .rst_n, .sda_oe, .scl_oe, .hold_sda,
		.hold_scl, .sda, .scl);

	// 50 mhz clock
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// bounded wait: 0 scl free, 1 sda free, 2 event, 3 collision
	task automatic wait_on(input int sel, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
		while (cnt < 600 && !(sel == 0 ? scl_oe === 1'b0 : sel == 1 ? sda_oe === 1'b0 :
			sel == 2 ? port_event_flag === 1'b1 : collision_flag === 1'b1));
		if (cnt >= 600)
			chk(8'h00, 8'h01);
	endtask

	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#400000;
		failures++;
		close_out;
	end

	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		hold_sda = 1'b0;
		hold_scl = 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		// reset values, unmapped index seven
		for (int i = 0; i < 8; i++)
			rd(3'(i), rst_tab[i]);
		// slave layout: bit two is a mask bit
		wr(3'h3, 8'h04);
		rd(3'h3, 8'h04);
		chk({7'h0, stop_request_bit}, 8'h00);
		// mask shares the reload index
		wr(3'h2, 8'h29);
		wr(3'h1, 8'h5a);
		rd(3'h1, 8'h5a);
		wr(3'h2, 8'h28);
		rd(3'h1, 8'h00);
		$display("register test done");
		// clean stops at reload 3 and 8, buffer write refused meanwhile;
		// below 2 the expiry comes before the synchronised data line rises
		wr(3'h6, 8'h03);
		for (int r = 3; r < 12; r += 5)
		begin
			wr(3'h1, 8'(r));
			wr(3'h3, 8'h04);
			wait_on(0, n);
			wr(3'h0, 8'h77);
			wait_on(1, n);
			chk(8'(n >= r + 8 && n <= r + 18), 8'h01);
			wait_on(2, m);
			chk(8'(m >= 2 * r + 3 && m <= 2 * r + 10), 8'h01);
			#40;
			chk({6'h0, stop_request_bit, irq}, 8'h01);
			rd(3'h4, 8'h10);
			rd(3'h5, 8'h01);
			rd(3'h5, 8'h00);
			rd(3'h2, 8'ha8);
			rd(3'h0, 8'h00);
			wr(3'h2, 8'h28);
			$display("stop test done, reload %0d", r);
		end
		// another master holds sda after release, interrupt masked
		wr(3'h6, 8'h00);
		wr(3'h3, 8'h04);
		wait_on(0, n);
		hold_sda <= 1'b1;
		wait_on(3, n);
		#40;
		chk({4'h0, sda_oe, scl_oe, stop_request_bit, irq}, 8'h00);
		wr(3'h6, 8'h03);
		#60;
		chk({7'h0, irq}, 8'h01);
		rd(3'h5, 8'h02);
		rd(3'h4, 8'h00);
		hold_sda <= 1'b0;
		#60;
		chk({7'h0, irq}, 8'h00);
		$display("sda collision test done");
		// scl pulled low while sda still held
		wr(3'h1, 8'h1e);
		wr(3'h3, 8'h04);
		wait_on(0, n);
		#300;
		chk({7'h0, sda_oe}, 8'h01);
		hold_scl <= 1'b1;
		wait_on(3, n);
		chk(8'(n <= 8), 8'h01);
		#40;
		chk({5'h0, sda_oe, scl_oe, stop_request_bit}, 8'h00);
		rd(3'h5, 8'h02);
		hold_scl <= 1'b0;
		$display("scl collision test done");
		close_out;
	end
endmodule // imscd_stop_bench
`default_nettype wire

// file: verif/imscd_stop_sva.sv
// checker of the stop and collision logic ports
`timescale 1ns/1ns
`default_nettype none
module imscd_stop_sva (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// register port
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// bus lines
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       scl_o,
	input wire logic       scl_oe,
	// flags
	input wire logic       stop_request_bit,
	input wire logic       collision_flag,
	input wire logic       port_event_flag,
	input wire logic       irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_drive_low; sda_o == 1'b0 && scl_o == 1'b0; endproperty
	a_drive_low: assert property (p_drive_low) else $error("line driven high");
	property p_req; $rose(stop_request_bit) |-> sda_oe; endproperty
	a_req: assert property (p_req) else $error("request without sda low");
	property p_scl_rel; $fell(scl_oe) && sda_oe |-> $past(!sda_i, 2); endproperty
	a_scl_rel: assert property (p_scl_rel) else $error("scl released early");
	property p_sda_rel; $fell(sda_oe) |-> !scl_oe; endproperty
	a_sda_rel: assert property (p_sda_rel) else $error("sda released first");
	property p_collide; $rose(collision_flag) |-> !sda_oe && !scl_oe && !stop_request_bit;
	endproperty
	a_collide: assert property (p_collide) else $error("collision not aborted");
	property p_event; $rose(port_event_flag) |-> !stop_request_bit && !sda_oe && !scl_oe;
	endproperty
	a_event: assert property (p_event) else $error("event while busy");
	property p_irq; !(collision_flag || port_event_flag) && $past(!(collision_flag ||
		port_event_flag)) |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_rdata; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rdata: assert property (p_rdata) else $error("stray read data");
	c_event: cover property ($rose(port_event_flag));
	c_coll: cover property ($rose(collision_flag));
	c_irq: cover property ($rose(irq));
endmodule // imscd_stop_sva
bind imscd_stop imscd_stop_sva imscd_stop_sva_i (.core_clk, .rst_n, .reg_rd, .reg_rdata,
	.sda_i, .sda_o, .sda_oe, .scl_o, .scl_oe, .stop_request_bit, .collision_flag,
	.port_event_flag, .irq);
`default_nettype wire
